// ===== verilog/tmsb_temp_monitor.sv
// serial slave, temperature registers and alarms of the monitor
//
// Operation
// R1 - only write, read, send, receive byte transfers
// R2 - write byte stores data at command register
// R3 - receive byte returns last selected register
// R4 - alert response read returns own address
// R5 - all registers eight bits, command selected
// R6 - multimaster hosts avoid short protocols
// R7 - temperatures unsigned bytes at 00h, 01h
// R8 - temperature bytes shifted out MSB first
// R9 - three eighth-degree bits at 05h, 06h
// R10 - negative temperature saturates to zero
// R11 - extended read freezes main register quarter second
// R12 - conversions at four per second from reset
// R13 - configuration bit 7 shuts down conversions
// R14 - overtemp sets status, drives output unmasked
// R15 - thermal threshold sets status, unmasked output
// R16 - masked thermal still sets status only
// R17 - alarms clear five degrees below threshold
// R18 - thermal alarm forces both fans full
// R19 - long low clock resets serial state
// R20 - overtemp output active-low open drain
// R21 - compare once per conversion, strictly greater; the clear compare runs every cycle
// R22 - ignore other slave addresses
`timescale 1ns/10ps
module tmsb_temp_monitor
    import tmsb_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = DEF_SLAVE_ADDR,
    parameter int CONV_CYCLES_P = CONV_CYCLES,
    parameter int LOCK_CYCLES_P = LOCK_CYCLES,
    parameter int TIMEOUT_CYCLES_P = TIMEOUT_CYCLES
)
(
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [RAW_W-1:0] CH1_SAMPLE,
    input wire logic [RAW_W-1:0] CH2_SAMPLE,
    output logic CONV_STROBE,
    output logic OVERTEMP_ALARM_OUT_N,
    output logic OVERTEMP_ALARM_OE,
    input wire logic THERMAL_ALARM_IN_N,
    output logic THERMAL_ALARM_OUT_N,
    output logic THERMAL_ALARM_OE,
    input wire logic FAN1_DUTY_IN,
    input wire logic FAN2_DUTY_IN,
    output logic FAN1_DRIVE_OUT,
    output logic FAN2_DRIVE_OUT
);

    // signed sample to clipped whole and eighths
    function automatic tmsb_temp_t clip_sample(input logic [RAW_W-1:0] raw);
        tmsb_temp_t res;
        res = '0;
        if (!raw[RAW_W-1])
        begin
            res.whole = raw[RAW_W-2:3];
            res.frac = raw[2:0];
        end
        return res;
    endfunction

    // set beats clear; clear needs temp+5 <= threshold
    function automatic logic alarm_next(input logic cur, input logic chk, input logic [7:0] temp,
                                        input logic [7:0] thr);
        logic set_now;
        logic clr_now;
        set_now = chk && (temp > thr);
        clr_now = ({1'b0, temp} + HYST_DEG) <= {1'b0, thr};
        return set_now | (cur & ~clr_now);
    endfunction

    // serial front end state
    tmsb_state_t state_ff, nxt_state;
    logic scl_q_ff;
    logic sda_q_ff;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] tx_ff, nxt_tx;
    logic [7:0] ptr_ff, nxt_ptr;
    logic rw_ff, nxt_rw;
    logic ara_ff, nxt_ara;
    logic sda_oe_ff, nxt_sda_oe;
    logic [CNT_W-1:0] tout_cnt_ff;
    logic wr_en;
    logic rd_load;

    // register and measurement state
    logic [7:0] config_ff;
    logic [7:0] fan1_opt_ff;
    logic [7:0] fan2_opt_ff;
    logic [3:0] mask_ff;
    logic [3:0] status_ff;
    logic [NUM_ALARM-1:0] nxt_status;
    logic [CNT_W-1:0] conv_cnt_ff;
    logic conv_q_ff;
    tmsb_temp_t [NUM_CH-1:0] live_ff;
    tmsb_temp_t [NUM_CH-1:0] shown_ff;
    tmsb_temp_t [NUM_CH-1:0] conv_val;
    logic [NUM_CH-1:0] lock_ff;
    logic [NUM_CH-1:0][CNT_W-1:0] lock_cnt_ff;
    logic [NUM_CH-1:0] rd_main;
    logic [NUM_CH-1:0] rd_frac;
    logic [NUM_ALARM-1:0][7:0] thr_words;
    logic [7:0] thr_rdata;

    // output flops
    logic ov_oe_ff;
    logic th_oe_ff;
    logic fan1_ff;
    logic fan2_ff;
    logic zero_ff;

    // bus condition decode
    wire scl_rise = SCL_IN & ~scl_q_ff;
    wire scl_fall = ~SCL_IN & scl_q_ff;
    wire start_cond = SCL_IN & scl_q_ff & sda_q_ff & ~SDA_IN;
    wire stop_cond = SCL_IN & scl_q_ff & ~sda_q_ff & SDA_IN;
    wire bus_timeout = (tout_cnt_ff == CNT_W'(TIMEOUT_CYCLES_P - 1)); // [R19]
    wire rx_state = (state_ff == ST_ADDR) || (state_ff == ST_CMD) || (state_ff == ST_WDATA);
    wire byte_full = (bit_cnt_ff == BYTE_BITS);
    wire own_hit = (shift_ff[7:1] == SLAVE_ADDR); // [R22]
    wire ara_hit = (shift_ff[7:1] == ARA_ADDR) && shift_ff[0]; // [R4]
    wire addr_hit = own_hit | ara_hit; // [R22]

    // register decode
    wire thr_hit = (ptr_ff[7:2] == REG_THR_BASE[7:2]);
    wire shutdown = config_ff[CFG_SHUTDOWN_BIT]; // [R13]
    wire conv_tick = (conv_cnt_ff == '0) && !shutdown; // [R12] [R13]
    wire sel_t1 = (ptr_ff == REG_CH1_TEMP);
    wire sel_t2 = (ptr_ff == REG_CH2_TEMP);
    wire sel_f1 = (ptr_ff == REG_CH1_FRAC);
    wire sel_f2 = (ptr_ff == REG_CH2_FRAC);
    wire sel_st = (ptr_ff == REG_ALARM_STATUS);
    wire sel_mk = (ptr_ff == REG_ALARM_MASK);
    wire sel_cf = (ptr_ff == REG_GEN_CONFIG);
    wire sel_fa1 = (ptr_ff == REG_FAN1_OPT);
    wire sel_fa2 = (ptr_ff == REG_FAN2_OPT);

    // read mux; unmapped commands answer zero
    wire [7:0] rd_byte = sel_t1 ? shown_ff[0].whole : // [R7]
                         sel_t2 ? shown_ff[1].whole : // [R7]
                         sel_f1 ? {shown_ff[0].frac, FRAC_PAD} : // [R9]
                         sel_f2 ? {shown_ff[1].frac, FRAC_PAD} : // [R9]
                         sel_st ? {STATUS_PAD, status_ff} :
                         sel_mk ? {STATUS_PAD, mask_ff} :
                         sel_cf ? config_ff :
                         sel_fa1 ? fan1_opt_ff :
                         sel_fa2 ? fan2_opt_ff :
                         thr_hit ? thr_rdata : 8'h00; // [R5]

    // lock events; alert response reads lock nothing
    wire rd_evt = rd_load & ~ara_ff;
    assign rd_main = {rd_evt & sel_t2, rd_evt & sel_t1};
    assign rd_frac = {rd_evt & sel_f2, rd_evt & sel_f1};

    // status always sets; mask only gates the pin
    wire ov_active = |(status_ff[1:0] & ~mask_ff[1:0]); // [R14]
    wire th_active = |(status_ff[3:2] & ~mask_ff[3:2]); // [R15] [R16]
    wire thermal_alarm_out_any = th_oe_ff | ~THERMAL_ALARM_IN_N; // [R18]
    wire fan_force = thermal_alarm_out_any & (fan1_opt_ff[FAN_THERMAL_ALARM_OUT_FULL_BIT] | fan2_opt_ff[FAN_THERMAL_ALARM_OUT_FULL_BIT]); // [R18]

    // slave sequencer; timeout, start, stop win
    always_comb
    begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_tx = tx_ff;
        nxt_ptr = ptr_ff;
        nxt_rw = rw_ff;
        nxt_ara = ara_ff;
        nxt_sda_oe = sda_oe_ff;
        wr_en = 1'b0;
        rd_load = 1'b0;
        if (bus_timeout)
        begin
            nxt_state = ST_IDLE; // [R19]
            nxt_sda_oe = 1'b0;
        end
        else if (start_cond)
        begin
            nxt_state = ST_ADDR;
            nxt_bit_cnt = 4'h0;
            nxt_sda_oe = 1'b0;
        end
        else if (stop_cond)
        begin
            nxt_state = ST_IDLE;
            nxt_sda_oe = 1'b0;
        end
        else if (rx_state && scl_rise && !byte_full)
        begin
            nxt_shift = {shift_ff[6:0], SDA_IN};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
        end
        else if (scl_fall)
        begin
            case (state_ff)
                ST_ADDR:
                begin
                    if (byte_full)
                    begin
                        nxt_bit_cnt = 4'h0;
                        nxt_rw = shift_ff[0];
                        nxt_ara = ara_hit;
                        nxt_sda_oe = addr_hit; // [R22]
                        nxt_state = addr_hit ? ST_ADDR_ACK : ST_IDLE; // [R22]
                    end
                end
                ST_CMD:
                begin
                    if (byte_full)
                    begin
                        nxt_bit_cnt = 4'h0;
                        nxt_ptr = shift_ff; // [R5]
                        nxt_sda_oe = 1'b1;
                        nxt_state = ST_CMD_ACK;
                    end
                end
                ST_WDATA:
                begin
                    if (byte_full)
                    begin
                        nxt_bit_cnt = 4'h0;
                        wr_en = 1'b1; // [R2]
                        nxt_sda_oe = 1'b1;
                        nxt_state = ST_WDATA_ACK;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (rw_ff)
                    begin
                        rd_load = 1'b1; // [R3]
                        nxt_tx = ara_ff ? {SLAVE_ADDR, 1'b0} : rd_byte; // [R4] [R3]
                        nxt_sda_oe = ara_ff ? ~SLAVE_ADDR[6] : ~rd_byte[7]; // [R8]
                        nxt_bit_cnt = 4'h1;
                        nxt_state = ST_RDATA;
                    end
                    else
                    begin
                        nxt_sda_oe = 1'b0;
                        nxt_state = ST_CMD;
                    end
                end
                ST_CMD_ACK:
                begin
                    nxt_sda_oe = 1'b0;
                    nxt_state = ST_WDATA; // a stop here makes it a send byte [R1]
                end
                ST_WDATA_ACK:
                begin
                    nxt_sda_oe = 1'b0;
                    nxt_state = ST_IDLE; // further bytes are not acknowledged [R1]
                end
                ST_RDATA:
                begin
                    if (byte_full)
                    begin
                        nxt_sda_oe = 1'b0;
                        nxt_state = ST_RDATA_ACK;
                    end
                    else
                    begin
                        nxt_tx = {tx_ff[6:0], 1'b0}; // [R8]
                        nxt_sda_oe = ~tx_ff[6]; // [R8]
                        nxt_bit_cnt = bit_cnt_ff + 4'h1;
                    end
                end
                ST_RDATA_ACK:
                begin
                    nxt_state = ST_IDLE; // one byte per read [R1]
                end
                ST_IDLE:
                begin
                    nxt_state = ST_IDLE;
                end
                default:
                begin
                    nxt_state = ST_IDLE;
                    nxt_sda_oe = 1'b0;
                end
            endcase
        end
    end

    // serial flops; pins taken as synchronous
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            state_ff <= ST_IDLE;
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            ptr_ff <= 8'h00;
            rw_ff <= 1'b0;
            ara_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            scl_q_ff <= SCL_IN;
            sda_q_ff <= SDA_IN;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            tx_ff <= nxt_tx;
            ptr_ff <= nxt_ptr;
            rw_ff <= nxt_rw;
            ara_ff <= nxt_ara;
            sda_oe_ff <= nxt_sda_oe;
        end
    end

    // clock-low timer; idle counting is harmless
    always_ff @(posedge REF_CLK)
    begin
        if (SRST || SCL_IN || bus_timeout)
        begin
            tout_cnt_ff <= '0;
        end
        else
        begin
            tout_cnt_ff <= tout_cnt_ff + CNT_W'(1); // [R19]
        end
    end

    // writable registers; read-only ones drop data
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            config_ff <= GEN_CONFIG_RST;
            fan1_opt_ff <= FAN_OPT_RST;
            fan2_opt_ff <= FAN_OPT_RST;
            mask_ff <= ALARM_MASK_RST;
        end
        else if (wr_en)
        begin
            if (sel_cf)
            begin
                config_ff <= shift_ff; // [R2] [R13]
            end
            if (sel_fa1)
            begin
                fan1_opt_ff <= shift_ff; // [R2]
            end
            if (sel_fa2)
            begin
                fan2_opt_ff <= shift_ff; // [R2]
            end
            if (sel_mk)
            begin
                mask_ff <= shift_ff[3:0]; // [R2]
            end
        end
    end

    // threshold words live in their own store
    tmsb_thr_mem u_thr_mem (
        .clk(REF_CLK),
        .rst(SRST),
        .wr_en(wr_en & thr_hit), // [R2]
        .wr_idx(ptr_ff[1:0]),
        .wr_data(shift_ff),
        .rd_idx(ptr_ff[1:0]),
        .rd_data(thr_rdata),
        .words(thr_words)
    );

    // conversion timer; reset value converts at once
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            conv_cnt_ff <= '0;
            conv_q_ff <= 1'b0;
        end
        else
        begin
            conv_cnt_ff <= (conv_cnt_ff == '0) ? CNT_W'(CONV_CYCLES_P - 1) : conv_cnt_ff - CNT_W'(1); // [R12]
            conv_q_ff <= conv_tick;
        end
    end

    // per-channel clipping and alarm evaluation
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            assign conv_val[gi] = clip_sample(gi == 0 ? CH1_SAMPLE : CH2_SAMPLE); // [R10]
        end
        for (gi = 0; gi < NUM_ALARM; gi++)
        begin : g_alarm
            // set on captures only; live clear acts at once on a raised threshold
            assign nxt_status[gi] = alarm_next(status_ff[gi], conv_q_ff, live_ff[gi % NUM_CH].whole,
                                               thr_words[gi]); // [R21] [R17] [R14] [R15] [R16]
        end
    endgenerate

    // results and read lock; frozen pair stays coherent
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            live_ff <= '0;
            shown_ff <= '0;
            lock_ff <= '0;
            lock_cnt_ff <= '0;
        end
        else
        begin
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                if (conv_tick)
                begin
                    live_ff[ch] <= conv_val[ch]; // [R12]
                end
                if (conv_tick && !lock_ff[ch])
                begin
                    shown_ff[ch] <= conv_val[ch]; // [R7] [R9] [R11]
                end
                if (rd_main[ch])
                begin
                    lock_ff[ch] <= 1'b0; // [R11]
                end
                else if (rd_frac[ch])
                begin
                    lock_ff[ch] <= 1'b1; // [R11]
                    lock_cnt_ff[ch] <= CNT_W'(LOCK_CYCLES_P - 1);
                end
                else if (lock_ff[ch] && lock_cnt_ff[ch] == '0)
                begin
                    lock_ff[ch] <= 1'b0; // [R11]
                end
                else if (lock_ff[ch])
                begin
                    lock_cnt_ff[ch] <= lock_cnt_ff[ch] - CNT_W'(1);
                end
            end
        end
    end

    // status flags and registered pins
    always_ff @(posedge REF_CLK)
    begin
        if (SRST)
        begin
            status_ff <= 4'h0;
            ov_oe_ff <= 1'b0;
            th_oe_ff <= 1'b0;
            fan1_ff <= 1'b0;
            fan2_ff <= 1'b0;
            zero_ff <= 1'b0;
        end
        else
        begin
            status_ff <= nxt_status; // [R17]
            ov_oe_ff <= ov_active; // [R20] [R14]
            th_oe_ff <= th_active; // [R15] [R16]
            fan1_ff <= fan_force | FAN1_DUTY_IN; // [R18]
            fan2_ff <= fan_force | FAN2_DUTY_IN; // [R18]
            zero_ff <= 1'b0;
        end
    end

    // open-drain pins only ever pull low
    assign SDA_OUT = zero_ff;
    assign SDA_OE = sda_oe_ff;
    assign OVERTEMP_ALARM_OUT_N = zero_ff; // [R20]
    assign OVERTEMP_ALARM_OE = ov_oe_ff; // [R20]
    assign THERMAL_ALARM_OUT_N = zero_ff;
    assign THERMAL_ALARM_OE = th_oe_ff;
    assign FAN1_DRIVE_OUT = fan1_ff;
    assign FAN2_DRIVE_OUT = fan2_ff;
    assign CONV_STROBE = conv_q_ff;

endmodule

// ===== common/tmsb_pkg.sv
// constants, types and register map of the monitor
package tmsb_pkg;

    // clock rate and times
    localparam int CLK_KHZ = 200000;
    localparam int CONV_PERIOD_MS = 250;
    localparam int LOCK_TIME_MS = 250;
    localparam int BUS_TIMEOUT_MS = 58;
    localparam int CONV_CYCLES = CONV_PERIOD_MS * CLK_KHZ;
    localparam int LOCK_CYCLES = LOCK_TIME_MS * CLK_KHZ;
    localparam int TIMEOUT_CYCLES = BUS_TIMEOUT_MS * CLK_KHZ;
    localparam int CNT_W = 26;

    // register map, command byte values
    localparam logic [7:0] REG_CH1_TEMP = 8'h00;
    localparam logic [7:0] REG_CH2_TEMP = 8'h01;
    localparam logic [7:0] REG_ALARM_STATUS = 8'h02;
    localparam logic [7:0] REG_ALARM_MASK = 8'h03;
    localparam logic [7:0] REG_GEN_CONFIG = 8'h04;
    localparam logic [7:0] REG_CH1_FRAC = 8'h05;
    localparam logic [7:0] REG_CH2_FRAC = 8'h06;
    localparam logic [7:0] REG_THR_BASE = 8'h08;
    localparam logic [7:0] REG_FAN1_OPT = 8'h13;
    localparam logic [7:0] REG_FAN2_OPT = 8'h17;

    // field positions and reset values
    localparam int CFG_SHUTDOWN_BIT = 7;
    localparam int FAN_THERMAL_ALARM_OUT_FULL_BIT = 6;
    localparam logic [7:0] GEN_CONFIG_RST = 8'h00;
    localparam logic [7:0] FAN_OPT_RST = 8'h00;
    localparam logic [3:0] ALARM_MASK_RST = 4'h0;
    localparam logic [7:0] THR_RST = 8'h64;
    localparam logic [4:0] FRAC_PAD = 5'h00;
    localparam logic [3:0] STATUS_PAD = 4'h0;

    // alarm hysteresis in degrees
    localparam logic [8:0] HYST_DEG = 9'h005;

    // bus addresses; the slave address default is arbitrary
    localparam logic [6:0] ARA_ADDR = 7'h0C;
    localparam logic [6:0] DEF_SLAVE_ADDR = 7'h2A;

    localparam int NUM_CH = 2;
    localparam int NUM_ALARM = 4;
    localparam int RAW_W = 12;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_CMD = 4'h3,
        ST_CMD_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RDATA_ACK = 4'h8
    } tmsb_state_t;

    // one temperature result: whole degrees and eighths
    typedef struct packed {
        logic [7:0] whole;
        logic [2:0] frac;
    } tmsb_temp_t;

endpackage

// ===== verilog/tmsb_thr_mem.sv
// threshold store with registered read port
`timescale 1ns/10ps
module tmsb_thr_mem
    import tmsb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [1:0] rd_idx,
    output logic [7:0] rd_data,
    output logic [NUM_ALARM-1:0][7:0] words
);

    // all words exposed since every alarm compares at once
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            words <= {NUM_ALARM{THR_RST}};
            rd_data <= 8'h00;
        end
        else
        begin
            if (wr_en)
            begin
                words[wr_idx] <= wr_data;
            end
            rd_data <= words[rd_idx];
        end
    end

endmodule

// ===== testbench/tmsb_temp_monitor_asserts.sv
// port checks for the monitor
`timescale 1ns/10ps
module tmsb_temp_monitor_asserts
#(
    parameter int CONV_CYCLES_P = 200,
    parameter int TIMEOUT_CYCLES_P = 100
)
(
    input logic REF_CLK,
    input logic SRST,
    input logic SCL_IN,
    input logic SDA_OE,
    input logic CONV_STROBE,
    input logic OVERTEMP_ALARM_OUT_N,
    input logic THERMAL_ALARM_OUT_N,
    input logic FAN1_DUTY_IN,
    input logic FAN2_DUTY_IN,
    input logic FAN1_DRIVE_OUT,
    input logic FAN2_DRIVE_OUT
);
    int ph_ff;
    int lo_ff;

    // conversion phase; clock-low length
    always_ff @(posedge REF_CLK)
    begin
        ph_ff <= (SRST || ph_ff == CONV_CYCLES_P - 1) ? 0 : ph_ff + 1;
        lo_ff <= (SRST || SCL_IN) ? 0 : lo_ff + 1;
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SRST);

    sequence s_pulse;
        CONV_STROBE ##1 !CONV_STROBE;
    endsequence

    AST_CONV_PHASE: assert property (CONV_STROBE |-> ph_ff == 1)
        else $error("strobe off period");
    AST_STROBE_PULSE: assert property (CONV_STROBE |-> s_pulse)
        else $error("strobe too long");
    AST_SDA_LOW_PHASE: assert property ($changed(SDA_OE) |-> !SCL_IN)
        else $error("sda moved, scl high");
    AST_BUS_TIMEOUT: assert property (lo_ff == TIMEOUT_CYCLES_P + 4 |-> !SDA_OE)
        else $error("sda held past timeout");
    AST_OV_DRAIN: assert property (!OVERTEMP_ALARM_OUT_N)
        else $error("overtemp pin high");
    AST_TH_DRAIN: assert property (!THERMAL_ALARM_OUT_N)
        else $error("thermal pin high");
    AST_FAN_DUTY: assert property (FAN1_DUTY_IN && FAN2_DUTY_IN |=> FAN1_DRIVE_OUT && FAN2_DRIVE_OUT)
        else $error("fan duty lost");
    AST_FAN_PAIR: assert property (FAN1_DRIVE_OUT != FAN2_DRIVE_OUT |->
        $past(FAN1_DUTY_IN) != $past(FAN2_DUTY_IN))
        else $error("fans forced singly");
endmodule
bind tmsb_temp_monitor tmsb_temp_monitor_asserts #(.CONV_CYCLES_P(CONV_CYCLES_P),
    .TIMEOUT_CYCLES_P(TIMEOUT_CYCLES_P)) u_chk (.*);

// ===== testbench/tmsb_smb_host.sv
// smbus host model on the monitor's serial pins
`timescale 1ns/10ps
module tmsb_smb_host
#(
    parameter int H = 4
)
(
    input logic clk,
    input logic sda_in,
    output logic scl = 1'b1,
    output logic sda_low = 1'b0,
    output logic rd_valid = 1'b0,
    output logic [7:0] rd_data = 8'h00
);
    // one phase of a bit
    task automatic hw();
        repeat (H) @(negedge clk);
    endtask

    // start or repeated start
    task automatic start_c();
        sda_low = 1'b0;
        hw();
        scl = 1'b1;
        hw();
        sda_low = 1'b1;
        hw();
        scl = 1'b0;
        hw();
    endtask

    task automatic stop_c();
        sda_low = 1'b1;
        hw();
        scl = 1'b1;
        hw();
        sda_low = 1'b0;
        hw();
    endtask

    // data moves while the clock is low, sampled before the fall
    task automatic bit_io(input logic b, output logic s);
        sda_low = !b;
        hw();
        scl = 1'b1;
        hw();
        s = sda_in;
        scl = 1'b0;
        hw();
    endtask

    // msb first; ninth bit is ack or our nack
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ak);
        logic a;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(1'b1, a);
        ak = !a;
    endtask

    // k: 0 write, 1 send, 2 read, 3 receive byte only
    task automatic tr(input logic [6:0] a, input int k, input logic [7:0] c, w, output logic [7:0] q,
        output logic ak);
        logic x;
        start_c();
        xfer({a, k == 3}, q, ak);
        if (k < 3) xfer(c, q, x);
        if (k == 0) xfer(w, q, x);
        if (k == 2) start_c();
        if (k == 2) xfer({a, 1'b1}, q, x);
        if (k > 1) xfer(8'hFF, q, x);
        stop_c();
        rd_valid = k > 1 && ak;
        rd_data = q;
        @(negedge clk);
        rd_valid = 1'b0;
    endtask
endmodule

// ===== testbench/tmsb_temp_monitor_tb.sv
// self-checking bench of the monitor
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t %h %h", $time, g, e); end end
module tmsb_temp_monitor_tb
    import tmsb_pkg::*;
;
    localparam int CONV = 200;
    localparam int LOCK = 3000;
    localparam logic [6:0] SA = DEF_SLAVE_ADDR;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ext_th = 1'b0;
    logic f1 = 1'b0;
    logic f2 = 1'b0;
    logic [11:0] ch1 = 12'h000;
    logic [11:0] ch2 = 12'hFE8;
    logic scl, sda_low, rd_valid, sda_oe, strobe, ov, th_oe, fd1, fd2, ak;
    logic [7:0] rd_data, exp_v, w;
    logic [7:0] exp_q[$];
    logic [7:0] regs[6] = '{8'h04, 8'h13, 8'h17, 8'h02, 8'h03, 8'h30};
    logic [2:0] fr;
    int n_compared = 0;
    int miscompares = 0;
    int n_conv = 0;
    int k;
    // open-drain wires
    wire sda_w = !(sda_low | sda_oe);
    wire th_w = !(th_oe | ext_th);

    tmsb_temp_monitor #(.CONV_CYCLES_P(CONV), .LOCK_CYCLES_P(LOCK), .TIMEOUT_CYCLES_P(100)) uut (
        .REF_CLK(clk), .SRST(srst), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(), .SDA_OE(sda_oe),
        .CH1_SAMPLE(ch1), .CH2_SAMPLE(ch2), .CONV_STROBE(strobe), .OVERTEMP_ALARM_OUT_N(),
        .OVERTEMP_ALARM_OE(ov), .THERMAL_ALARM_IN_N(th_w), .THERMAL_ALARM_OUT_N(),
        .THERMAL_ALARM_OE(th_oe), .FAN1_DUTY_IN(f1), .FAN2_DUTY_IN(f2), .FAN1_DRIVE_OUT(fd1),
        .FAN2_DRIVE_OUT(fd2));
    tmsb_smb_host host (.clk(clk), .sda_in(sda_w), .scl(scl), .sda_low(sda_low), .rd_valid(rd_valid),
        .rd_data(rd_data));

    // clock, random fan duty, conversion count
    always #2.5 clk = ~clk;
    always @(negedge clk) {f1, f2} <= 2'($urandom);
    always @(posedge clk) if (strobe === 1'b1) n_conv++;

    // each read result against the oldest note
    always @(posedge clk)
    begin
        if (rd_valid === 1'b1 && exp_q.size() > 0)
        begin
            exp_v = exp_q.pop_front();
            `CHK(rd_data, exp_v)
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic op(input logic [6:0] a, input int k, input logic [7:0] c, wd, e, input logic ea);
        logic [7:0] q;
        logic ok;
        if (k > 1 && ea) exp_q.push_back(e);
        host.tr(a, k, c, wd, q, ok);
        `CHK(ok, ea)
    endtask

    task automatic rd(input logic [7:0] c, e);
        op(SA, 2, c, 8'h00, e, 1'b1);
    endtask

    task automatic wr(input logic [7:0] c, wd);
        op(SA, 0, c, wd, 8'h00, 1'b1);
    endtask

    // fans held full whatever the duty inputs do
    task automatic full();
        repeat (8)
        begin
            cyc(1);
            `CHK({fd1, fd2}, 2'h3)
        end
    endtask

    task automatic endt(input string s);
        $display("test %0s finished", s);
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial
    begin
        void'($urandom(32'hE288));
        w = 8'($urandom_range(99, 0));
        fr = 3'($urandom);
        ch1 = {1'b0, w, fr};
        cyc(20);
        srst = 1'b0;
        cyc(2);
        rd(REG_CH1_FRAC, {fr, 5'h00});
        rd(REG_CH1_TEMP, w);
        rd(REG_CH2_TEMP, 8'h00);
        rd(8'h08, 8'h64);
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(REG_CH2_TEMP, 8'h77);
        rd(REG_CH2_TEMP, 8'h00);
        wr(REG_GEN_CONFIG, 8'h05);
        op(SA, 3, 8'h00, 8'h00, 8'h05, 1'b1);
        op(SA, 1, REG_FAN2_OPT, 8'h00, 8'h00, 1'b1);
        op(SA, 3, 8'h00, 8'h00, 8'h00, 1'b1);
        op(ARA_ADDR, 3, 8'h00, 8'h00, {SA, 1'b0}, 1'b1);
        op(SA ^ 7'h01, 2, 8'h00, 8'h00, 8'h00, 1'b0);
        endt("access");
        rd(REG_CH1_FRAC, {fr, 5'h00});
        ch1 = {1'b0, w + 8'h01, 3'h0};
        cyc(3 * CONV);
        rd(REG_CH1_TEMP, w);
        cyc(2 * CONV);
        rd(REG_CH1_TEMP, w + 8'h01);
        rd(REG_CH1_FRAC, 8'h00);
        ch1 = {1'b0, w + 8'h02, 3'h0};
        cyc(LOCK + 2 * CONV);
        rd(REG_CH1_TEMP, w + 8'h02);
        endt("lock");
        wr(REG_GEN_CONFIG, 8'h80);
        cyc(2);
        k = n_conv;
        cyc(3 * CONV);
        `CHK(n_conv, k)
        wr(REG_GEN_CONFIG, 8'h00);
        cyc(2);
        k = n_conv;
        cyc(2 * CONV);
        `CHK(n_conv, k + 2)
        endt("conversion");
        wr(REG_FAN1_OPT, 8'h40);
        ch1 = {1'b0, 8'h65, 3'h0};
        ch2 = {1'b0, 8'h64, 3'h0};
        cyc(2 * CONV);
        `CHK({ov, th_oe}, 2'h3)
        rd(REG_ALARM_STATUS, 8'h05);
        full();
        ch1 = {1'b0, 8'h60, 3'h0};
        cyc(2 * CONV);
        `CHK({ov, th_oe}, 2'h3)
        ch1 = {1'b0, 8'h5F, 3'h0};
        cyc(2 * CONV);
        `CHK({ov, th_oe}, 2'h0)
        rd(REG_ALARM_STATUS, 8'h00);
        wr(REG_ALARM_MASK, 8'h04);
        ch1 = {1'b0, 8'h65, 3'h0};
        cyc(2 * CONV);
        `CHK({ov, th_oe}, 2'h2)
        rd(REG_ALARM_STATUS, 8'h05);
        wr(8'h08, 8'h6A);
        `CHK(ov, 1'b0)
        ext_th = 1'b1;
        full();
        ext_th = 1'b0;
        endt("alarms");
        host.start_c();
        host.xfer({SA, 1'b1}, exp_v, ak);
        cyc(150);
        `CHK(sda_oe, 1'b0)
        host.stop_c();
        rd(REG_GEN_CONFIG, 8'h00);
        endt("timeout");
        summarize();
    end
endmodule
